// ---- pkg/tmr_params.svh ----
// Purpose: address map, field positions, reset values and timing counts of the timer block
// Assumes: 32-bit APB data, each register one aligned word
// Notes: definitions only
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define TMR_ADDR_W 8
`define TMR_OFS_CTRL 8'h00
`define TMR_OFS_COUNT 8'h04
`define TMR_OFS_STATUS 8'h08

// ****************************************************************
// control field positions
// ****************************************************************
`define TMR_BIT_RUN 15
`define TMR_BIT_IDLE_HALT 13
`define TMR_BIT_EXT_SRC_HI 9
`define TMR_BIT_EXT_SRC_LO 8
`define TMR_BIT_GATE_EN 6
`define TMR_BIT_PRESC_HI 5
`define TMR_BIT_PRESC_LO 4
`define TMR_BIT_SYNC_EN 2
`define TMR_BIT_CLK_SEL 1

// implemented bits 15,13,9,8,6,5,4,2,1
`define TMR_CTRL_WMASK 16'ha376
`define TMR_CTRL_RESET 16'h0000
`define TMR_COUNT_RESET 16'h0000

// ****************************************************************
// timing: device clock is the oscillator, 4 ns period
// ****************************************************************
`define TMR_CLK_PERIOD_NS 4
`define TMR_OSC_DIV 2
`define TMR_PRESC_LAST_1 8'h00
`define TMR_PRESC_LAST_8 8'h07
`define TMR_PRESC_LAST_64 8'h3f
`define TMR_PRESC_LAST_256 8'hff

`endif

// ---- pkg/tmr_pkg.sv ----
// Purpose: types shared by the timer block
// Assumes: nothing
// Notes: constants live in tmr_params.svh
package tmr_pkg;

	// ****************************************************************
	// field encodings
	// ****************************************************************
	typedef enum logic [1:0] {
		TMR_SRC_SECONDARY_OSC = 2'h0,
		TMR_SRC_DEDICATED_PIN = 2'h1,
		TMR_SRC_LOW_POWER_RC = 2'h2,
		TMR_SRC_GENERIC_PIN = 2'h3
	} tmr_ext_src_t;

	typedef enum logic [1:0] {
		TMR_DIV_1 = 2'h0,
		TMR_DIV_8 = 2'h1,
		TMR_DIV_64 = 2'h2,
		TMR_DIV_256 = 2'h3
	} tmr_presc_t;

	// one-hot bus answer states
	typedef enum logic [1:0] {
		TMR_BUS_WAIT = 2'b01,
		TMR_BUS_ACK = 2'b10
	} tmr_bus_st_t;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] count;
		tmr_bus_st_t bus_st;
		logic [31:0] prdata;
		logic pslverr;
		logic [7:0] div_cnt;
		logic ext_prev;
		logic ext_pend;
		logic rollover;
	} tmr_top_state_t;

	typedef struct packed {
		logic [7:0] cnt;
	} tmr_presc_state_t;

endpackage

// ---- rtl/tmr_sync3.sv ----
// Purpose: three-stage synchroniser bank for asynchronous pins
// Assumes: inputs unrelated to clk_in
// Notes: a new level is accepted once stages two and three agree
`timescale 1ns/1ps
module tmr_sync3 #(
	parameter int WIDTH = 5
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
	} tmr_sync_state_t;

	tmr_sync_state_t st_r;
	tmr_sync_state_t st_nxt;

	// ****************************************************************
	// per-bit chain; stage one feeds only stage two
	// ****************************************************************
	logic [WIDTH-1:0] lvl_pick;

	// hold last agreed level while stages two and three disagree
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			assign lvl_pick[gi] = (st_r.s2[gi] == st_r.s3[gi]) ? st_r.s3[gi] : st_r.lvl[gi];
		end
	endgenerate

	// one process fills the whole next state, so no field has two writers
	always_comb begin
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.lvl = lvl_pick;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level_out = st_r.lvl;

endmodule

// ---- rtl/tmr_prescaler.sv ----
// Purpose: divides the selected timer tick by 1, 8, 64 or 256
// Assumes: tick_in is a one-cycle enable on clk_in
// Notes: clear_in restarts the division from zero
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_prescaler #(
	parameter int CNT_W = 8
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic clear_in,
	input wire logic tick_in,
	input wire logic [1:0] select_in,
	output logic tick_out
);

	tmr_pkg::tmr_presc_state_t st_r;
	tmr_pkg::tmr_presc_state_t st_nxt;
	logic at_last;

	// last count value of each ratio
	function automatic logic [CNT_W-1:0] last_count(input logic [1:0] sel);
		logic [CNT_W-1:0] v;
		v = CNT_W'(`TMR_PRESC_LAST_1);
		unique case (tmr_pkg::tmr_presc_t'(sel))
			tmr_pkg::TMR_DIV_1: v = CNT_W'(`TMR_PRESC_LAST_1);
			tmr_pkg::TMR_DIV_8: v = CNT_W'(`TMR_PRESC_LAST_8);
			tmr_pkg::TMR_DIV_64: v = CNT_W'(`TMR_PRESC_LAST_64);
			tmr_pkg::TMR_DIV_256: v = CNT_W'(`TMR_PRESC_LAST_256);
		endcase
		return v;
	endfunction

	// ****************************************************************
	// division counter
	// ****************************************************************
	always_comb begin
		// >= also covers a ratio lowered mid-count
		at_last = (st_r.cnt >= last_count(select_in));
		st_nxt = st_r;
		if (clear_in) begin
			st_nxt.cnt = '0;
		end else if (tick_in) begin
			st_nxt.cnt = at_last ? '0 : st_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick_out = tick_in & at_last & ~clear_in;

endmodule

// ---- rtl/tmr_top.sv ----
// Purpose: 16-bit general timer with its control register, reached over APB
// Assumes: clk_in is the oscillator clock; source pins are asynchronous
// Notes: APB wait states are not used; every access answers in its first access cycle
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_top #(
	parameter int PRESC_W = 8,
	parameter int PIN_N = 5
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [`TMR_ADDR_W-1:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic idle_mode_in,
	input wire logic gate_in,
	input wire logic generic_ext_clk_pin_in,
	input wire logic dedicated_ext_clk_pin_in,
	input wire logic secondary_osc_in,
	input wire logic low_power_rc_osc_in,
	output logic [15:0] count_value_out,
	output logic running_out,
	output logic rollover_out
);

	tmr_pkg::tmr_top_state_t st_r;
	tmr_pkg::tmr_top_state_t st_nxt;

	// ****************************************************************
	// control fields
	// ****************************************************************
	logic count_run;
	logic idle_halt;
	logic [1:0] ext_source_select;
	logic gate_accumulate_en;
	logic [1:0] prescale_select;
	logic ext_sync_en;
	logic clock_source_sel;

	assign count_run = st_r.ctrl[`TMR_BIT_RUN];
	assign idle_halt = st_r.ctrl[`TMR_BIT_IDLE_HALT];
	assign ext_source_select = st_r.ctrl[`TMR_BIT_EXT_SRC_HI:`TMR_BIT_EXT_SRC_LO];
	assign gate_accumulate_en = st_r.ctrl[`TMR_BIT_GATE_EN];
	assign prescale_select = st_r.ctrl[`TMR_BIT_PRESC_HI:`TMR_BIT_PRESC_LO];
	assign ext_sync_en = st_r.ctrl[`TMR_BIT_SYNC_EN];
	assign clock_source_sel = st_r.ctrl[`TMR_BIT_CLK_SEL];

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] pin_lvl;
	logic gate_lvl;
	logic ext_lvl;

	// bit order: gate, generic, dedicated, secondary, low-power rc
	assign pin_raw = {low_power_rc_osc_in, secondary_osc_in, dedicated_ext_clk_pin_in,
		generic_ext_clk_pin_in, gate_in};

	tmr_sync3 #(
		.WIDTH(PIN_N)
	) u_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.async_in(pin_raw),
		.level_out(pin_lvl)
	);

	assign gate_lvl = pin_lvl[0];

	// extended source selection
	always_comb begin
		ext_lvl = 1'b0;
		unique case (tmr_pkg::tmr_ext_src_t'(ext_source_select))
			tmr_pkg::TMR_SRC_GENERIC_PIN: ext_lvl = pin_lvl[1];
			tmr_pkg::TMR_SRC_DEDICATED_PIN: ext_lvl = pin_lvl[2];
			tmr_pkg::TMR_SRC_SECONDARY_OSC: ext_lvl = pin_lvl[3];
			tmr_pkg::TMR_SRC_LOW_POWER_RC: ext_lvl = pin_lvl[4];
		endcase
	end

	// ****************************************************************
	// tick generation
	// ****************************************************************
	logic int_tick;
	logic ext_edge;
	logic ext_tick;
	logic src_tick;
	logic halted;
	logic presc_clear;
	logic count_tick;
	logic ctrl_wr;
	logic count_wr;

	// oscillator/2 enable pulse
	assign int_tick = (st_r.div_cnt == 8'(`TMR_OSC_DIV - 1));

	// rising edge of the chosen extended source
	assign ext_edge = ext_lvl & ~st_r.ext_prev;

	// synced mode waits for the next internal phase; costs up to one tick of latency
	assign ext_tick = ext_sync_en ? (st_r.ext_pend & int_tick) : ext_edge;

	// source select, with the gate applied to the internal clock only
	always_comb begin
		if (clock_source_sel) begin
			src_tick = ext_tick;
		end else if (gate_accumulate_en) begin
			src_tick = int_tick & gate_lvl;
		end else begin
			src_tick = int_tick;
		end
	end

	// stopped, or halted in idle when asked to
	assign halted = ~count_run | (idle_halt & idle_mode_in);

	// a control write also restarts the division, so a new ratio starts clean
	assign presc_clear = halted | ctrl_wr;

	tmr_prescaler #(
		.CNT_W(PRESC_W)
	) u_presc (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.clear_in(presc_clear),
		.tick_in(src_tick),
		.select_in(prescale_select),
		.tick_out(count_tick)
	);

	// ****************************************************************
	// latency and limits of the tick path
	// ****************************************************************
	// a pin edge passes three flops and the agreement stage, about four to five clocks
	// synced extended mode waits on top of that for the next internal phase
	// pin high and low phases shorter than two clocks can be lost in the synchroniser
	// the unsynchronised mode still uses the synchroniser, since the block has one clock
	// the gate pin goes through the same bank, so gating starts and stops late by the same amount
	// the gate only qualifies internal ticks; with an extended source it is never looked at
	// switching the extended source can show one false edge, as the edge memory
	// still holds the level of the pin that was selected before
	// software that cares should stop the timer, switch, then start it again
	// the prescaler restarts on every control write and while halted,
	// so a new ratio never inherits a partial count
	// a software count load beats a tick in the same cycle; that tick is lost
	// rollover is a single-cycle pulse in the cycle that shows the wrapped count
	// idle halting is immediate: idle_mode_in comes from this clock and needs no synchroniser

	// ****************************************************************
	// bus decode
	// ****************************************************************
	logic setup_ph;
	logic access_done;
	logic addr_ok;
	logic [15:0] wr_mask;
	logic [15:0] status_word;

	function automatic logic addr_hit(input logic [`TMR_ADDR_W-1:0] a);
		return (a == `TMR_OFS_CTRL) || (a == `TMR_OFS_COUNT) || (a == `TMR_OFS_STATUS);
	endfunction

	assign setup_ph = psel_in & ~penable_in;
	assign pready_out = psel_in & penable_in & (st_r.bus_st == tmr_pkg::TMR_BUS_ACK);
	assign access_done = pready_out;
	assign addr_ok = addr_hit(paddr_in);
	assign ctrl_wr = access_done & pwrite_in & (paddr_in == `TMR_OFS_CTRL);
	// count load from software
	assign count_wr = access_done & pwrite_in & (paddr_in == `TMR_OFS_COUNT);

	// byte lanes 0 and 1 cover the 16-bit registers
	assign wr_mask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

	// status: idle-halted, extended level, gate level, running
	assign status_word = {12'h000,
		idle_halt & idle_mode_in, // bit 3
		ext_lvl, // bit 2
		gate_lvl, // bit 1
		~halted}; // bit 0

	// byte-lane merge shared by both writable registers
	function automatic logic [15:0] merge_lanes(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [15:0] lanes);
		logic [15:0] v;
		v = (old_v & ~lanes) | (new_v & lanes);
		return v;
	endfunction

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.rollover = 1'b0;

		// oscillator divider runs freely
		if (int_tick) begin
			st_nxt.div_cnt = '0;
		end else begin
			st_nxt.div_cnt = st_r.div_cnt + 8'h01;
		end

		// edge memory and pending synced edge; a new edge beats the consume
		st_nxt.ext_prev = ext_lvl;
		st_nxt.ext_pend = (st_r.ext_pend & ~int_tick) | ext_edge;

		// counter advances only while running
		if (count_tick) begin
			st_nxt.count = st_r.count + 16'h0001;
			st_nxt.rollover = (st_r.count == 16'hffff);
		end

		// bus answer: data latched in setup, handed over in first access cycle
		unique case (st_r.bus_st)
			tmr_pkg::TMR_BUS_WAIT: begin
				if (setup_ph) begin
					st_nxt.bus_st = tmr_pkg::TMR_BUS_ACK;
					st_nxt.pslverr = ~addr_ok;
					st_nxt.prdata = 32'h0000_0000;
					if (!pwrite_in) begin
						unique case (paddr_in)
							`TMR_OFS_CTRL: st_nxt.prdata = {16'h0000, st_r.ctrl & `TMR_CTRL_WMASK};
							`TMR_OFS_COUNT: st_nxt.prdata = {16'h0000, st_r.count};
							`TMR_OFS_STATUS: st_nxt.prdata = {16'h0000, status_word};
							default: st_nxt.prdata = 32'h0000_0000;
						endcase
					end
				end
			end
			tmr_pkg::TMR_BUS_ACK: begin
				if (access_done) begin
					st_nxt.bus_st = tmr_pkg::TMR_BUS_WAIT;
					if (ctrl_wr) begin
						// unimplemented bits never store
						st_nxt.ctrl = merge_lanes(st_r.ctrl, pwdata_in[15:0], wr_mask) & `TMR_CTRL_WMASK;
					end
					if (count_wr) begin
						// software load wins over a tick in the same cycle
						st_nxt.count = merge_lanes(st_r.count, pwdata_in[15:0], wr_mask);
					end
				end else if (!psel_in) begin
					// master abandoned the transfer
					st_nxt.bus_st = tmr_pkg::TMR_BUS_WAIT;
				end
			end
			default: begin
				st_nxt.bus_st = tmr_pkg::TMR_BUS_WAIT;
			end
		endcase
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	// every field is listed so nothing is left to a default;
	// the bus answer always returns to waiting
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_r.ctrl <= `TMR_CTRL_RESET;
			st_r.count <= `TMR_COUNT_RESET;
			st_r.bus_st <= tmr_pkg::TMR_BUS_WAIT;
			st_r.prdata <= 32'h0000_0000;
			st_r.pslverr <= 1'b0;
			st_r.div_cnt <= 8'h00;
			st_r.ext_prev <= 1'b0;
			st_r.ext_pend <= 1'b0;
			st_r.rollover <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// data held until the next setup, so it is stable for the whole access
	assign prdata_out = st_r.prdata;
	assign pslverr_out = pready_out & st_r.pslverr;
	assign count_value_out = st_r.count;
	// combinational from idle_mode_in, so with idle halt set it drops in the cycle idle rises
	assign running_out = ~halted;
	assign rollover_out = st_r.rollover;

endmodule

// ---- tb/tmr_src_model.sv ----
// Purpose: far side of the timer: external clock pins and oscillators
// Assumes: sources are asynchronous to the device clock
// Notes: pins stand still low between bursts, like a stopped clock
`timescale 1ns/1ps
module tmr_src_model (
	output logic [3:0] pin_out
);
	// index: 0 secondary osc, 1 dedicated pin, 2 low-power rc, 3 generic pin
	initial pin_out = 4'h0;

	// burst of n rising edges; phases below 2 device clocks can be lost in the synchroniser
	task automatic pulse(input int idx, input int n, input real ph);
		repeat (n) begin
			pin_out[idx] = 1'b1;
			#(ph);
			pin_out[idx] = 1'b0;
			#(ph);
		end
	endtask
endmodule

// ---- tb/tmr_top_props.sv ----
// Purpose: port checks of the timer block
// Assumes: control word is shadowed from completed APB writes
// Notes: bound into every tmr_top
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_top_chk (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic idle_mode_in,
	input wire logic gate_in,
	input wire logic [15:0] count_value_out,
	input wire logic running_out,
	input wire logic rollover_out
);
	// ****************************************************************
	// shadow control word and age counters
	// ****************************************************************
	logic [15:0] sh_r;
	logic [15:0] prev_r;
	logic [10:0] stc_r;
	logic [9:0] gap_r;
	logic [3:0] glow_r;
	logic [15:0] wm;
	logic [9:0] per;
	logic acc;
	assign acc = psel_in && penable_in && pready_out;
	assign wm = `TMR_CTRL_WMASK & {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
	// tick period in device clocks: oscillator/2, then the prescaler
	assign per = (sh_r[5:4] == 2'h3) ? 10'h200 : (10'h2 << (3 * sh_r[5:4]));

	// stc_r: only a long undisturbed internal run is steady enough to time ticks
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sh_r <= 16'h0;
			prev_r <= 16'h0;
			stc_r <= 11'h0;
			gap_r <= 10'h0;
			glow_r <= 4'h0;
		end else begin
			if (acc && pwrite_in && !pslverr_out && paddr_in == `TMR_OFS_CTRL) begin
				sh_r <= (sh_r & ~wm) | (pwdata_in[15:0] & wm);
			end
			prev_r <= count_value_out;
			gap_r <= (count_value_out != prev_r) ? 10'h0 : gap_r + 10'h1;
			stc_r <= (running_out && !sh_r[1] && !sh_r[6] && !psel_in) ? stc_r + {10'h0, stc_r != 11'h7ff} : 11'h0;
			glow_r <= gate_in ? 4'h0 : glow_r + {3'h0, glow_r != 4'hf};
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_rd_ctrl;
		acc && !pwrite_in && paddr_in == `TMR_OFS_CTRL;
	endsequence
	sequence s_wrap;
		$past(count_value_out) == 16'hffff && count_value_out == 16'h0 && $past(running_out);
	endsequence

	AST_RUN_LEVEL: assert property (running_out == (sh_r[15] && !(sh_r[13] && idle_mode_in)))
		else $error("run level differs from control");
	AST_STOP_HOLD: assert property (!running_out && !psel_in |=> $stable(count_value_out))
		else $error("count moved while stopped");
	AST_STEP: assert property (!psel_in |=> count_value_out - $past(count_value_out) <= 16'h1)
		else $error("count jumped");
	AST_TICK_PERIOD: assert property (stc_r > 11'd1040 && count_value_out != prev_r |-> gap_r == per - 10'h1)
		else $error("tick period wrong");
	AST_GATE_HOLD: assert property (sh_r[6] && !sh_r[1] && glow_r == 4'hf && !psel_in |=> $stable(count_value_out))
		else $error("count moved with gate low");
	AST_IDLE_FREEZE: assert property ((sh_r[13] && idle_mode_in && !psel_in) [*3] |=> $stable(count_value_out))
		else $error("count moved in idle");
	AST_CTRL_READ: assert property (s_rd_ctrl |-> prdata_out == {16'h0, sh_r})
		else $error("control read wrong");
	AST_WRAP: assert property (s_wrap |-> ##[0:1] rollover_out)
		else $error("no wrap pulse");
	AST_RESET: assert property ($rose(rstn_in) |-> count_value_out == 16'h0 && !running_out)
		else $error("not clear after reset");
endmodule

bind tmr_top tmr_top_chk u_chk (.*);

// ---- tb/tb_basic_16bit_timer_control.sv ----
// Purpose: self-checking bench of the timer block
// Assumes: APB answers in its first access cycle
// Notes: source pins come from tmr_src_model
`timescale 1ns/1ps
`include "tmr_params.svh"
module tb_basic_16bit_timer_control;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic idle = 1'b0;
	logic gate = 1'b0;
	logic [3:0] pins;
	logic [15:0] cnt;
	logic running;
	logic rollover;
	logic [31:0] rd;
	logic er;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [15:0] ctl = 16'h0;
	logic [15:0] a;
	int err_count = 0;
	int checked = 0;
	int seed = 65;
	int n;

	always #2 clk_in = ~clk_in;

	tmr_top dut (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.paddr_in(paddr),
		.psel_in(psel),
		.penable_in(penable),
		.pwrite_in(pwrite),
		.pwdata_in(pwdata),
		.pstrb_in(pstrb),
		.prdata_out(prdata),
		.pready_out(pready),
		.pslverr_out(pslverr),
		.idle_mode_in(idle),
		.gate_in(gate),
		.generic_ext_clk_pin_in(pins[3]),
		.dedicated_ext_clk_pin_in(pins[1]),
		.secondary_osc_in(pins[0]),
		.low_power_rc_osc_in(pins[2]),
		.count_value_out(cnt),
		.running_out(running),
		.rollover_out(rollover)
	);
	tmr_src_model src (.pin_out(pins));

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [15:0] msk(input logic [3:0] s);
		return `TMR_CTRL_WMASK & {{8{s[1]}}, {8{s[0]}}};
	endfunction
	function automatic int dv(input int p);
		return (p == 3) ? 256 : 1 << (3 * p);
	endfunction

	// an X in got never passes: the parity test catches it first
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
		checked++;
		if (^got === 1'bx || got - exp + tol > 2 * tol) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one idle cycle before each setup keeps psel from being assigned twice in a step
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk_in);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (pready !== 1'b1 && k < 20);
		// a slave that never answers counts as a mismatch
		if (pready !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, pready, 1'b1);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// two count reads w+3 clocks apart
	task automatic meas(input int w, input logic [15:0] exp, input logic [15:0] tol);
		apb(1'b0, `TMR_OFS_COUNT, 32'h0, 4'h0);
		a = rd[15:0];
		repeat (w) @(posedge clk_in);
		apb(1'b0, `TMR_OFS_COUNT, 32'h0, 4'h0);
		chk({16'h0, rd[15:0] - a}, {16'h0, exp}, {16'h0, tol});
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
		apb(1'b0, `TMR_OFS_CTRL, 32'h0, 4'h0);
		chk(rd, 32'h0, 32'h0);
		chk({31'h0, running}, 32'h0, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			wd = (i == 0) ? 32'hffffffff : 32'($random(seed));
			ws = (i == 0) ? 4'hf : 4'($random(seed));
			apb(1'b1, `TMR_OFS_CTRL, wd, ws);
			ctl = (ctl & ~msk(ws)) | (wd[15:0] & msk(ws));
			apb(1'b0, `TMR_OFS_CTRL, 32'h0, 4'h0);
			chk(rd, {16'h0, ctl}, 32'h0);
		end
		apb(1'b0, 8'h0c, 32'h0, 4'h0);
		chk({er, rd[30:0]}, 32'h80000000, 32'h0);
		$display("test register done");
		// sync bit set on the ratios 8 and 256 must change nothing with the internal clock
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, `TMR_OFS_CTRL, 32'h8000 | (p << 4) | (p[0] << 2), 4'h3);
			meas(2045, 16'(1024 / dv(p)), 16'h1);
		end
		$display("test prescale done");
		for (int h = 0; h < 2; h++) begin
			apb(1'b1, `TMR_OFS_CTRL, 32'h8000 | (h << 13), 4'h3);
			idle <= 1'b1;
			meas(13, h ? 16'h0 : 16'h8, h ? 16'h0 : 16'h1);
			chk({31'h0, running}, 32'(1 - h), 32'h0);
			idle <= 1'b0;
		end
		$display("test idle done");
		apb(1'b1, `TMR_OFS_CTRL, 32'h8040, 4'h3);
		repeat (20) @(posedge clk_in);
		meas(13, 16'h0, 16'h0);
		gate <= 1'b1;
		repeat (10) @(posedge clk_in);
		meas(13, 16'h8, 16'h1);
		gate <= 1'b0;
		$display("test gate done");
		// a burst on a wrong source first, then the chosen one; gate held low throughout
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, `TMR_OFS_CTRL, 32'h8002 | (c << 8) | (c[0] << 2) | (c[1] << 6), 4'h3);
			repeat (10) @(posedge clk_in);
			apb(1'b0, `TMR_OFS_COUNT, 32'h0, 4'h0);
			a = rd[15:0];
			src.pulse((c + 1) % 4, 3, 12.5 + c * 7.3);
			src.pulse(c, 5, 12.5 + c * 7.3);
			repeat (12) @(posedge clk_in);
			apb(1'b0, `TMR_OFS_COUNT, 32'h0, 4'h0);
			chk({16'h0, rd[15:0] - a}, 32'h5, 32'h0);
		end
		$display("test sources done");
		apb(1'b1, `TMR_OFS_CTRL, 32'h0, 4'h3);
		apb(1'b1, `TMR_OFS_COUNT, 32'hfff0, 4'h3);
		apb(1'b1, `TMR_OFS_CTRL, 32'h8000, 4'h3);
		n = 0;
		while (rollover !== 1'b1 && n < 100) begin
			@(posedge clk_in);
			n++;
		end
		chk({31'h0, rollover}, 32'h1, 32'h0);
		$display("test wrap done");
		// reset again in mid-run: writable bits and the count must clear
		rstn_in <= 1'b0;
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
		apb(1'b0, `TMR_OFS_CTRL, 32'h0, 4'h0);
		chk(rd, 32'h0, 32'h0);
		apb(1'b0, `TMR_OFS_COUNT, 32'h0, 4'h0);
		chk(rd, 32'h0, 32'h0);
		$display("test second reset done");
		results();
	end

	// watchdog: the whole sequence needs about 9000 clocks
	initial begin
		repeat (40000) @(posedge clk_in);
		err_count++;
		results();
	end
endmodule
